// ---- design/mfi_decoder.sv ----
// Purpose: Decodes six multi-function terminals into drive control levels
// Assumes: Terminals are asynchronous pins; drive status is on sys_clk_in
// Notes: All outputs registered
`timescale 1ns/1ps
`default_nettype none

module mfi_decoder #(
  parameter int RECOVERY_UNIT_CYC = mfi_pkg::RECOVERY_UNIT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [5:0] terminal_in,
  input wire mfi_pkg::mfi_sel_wr_t sel_wr_in,
  input wire logic [2:0] sel_rd_idx_in,
  input wire logic load_defaults_in,
  input wire logic load_three_wire_in,
  input wire mfi_pkg::mfi_cfg_t cfg_in,
  input wire logic running_in,
  input wire logic panel_run_in,
  input wire logic remote_run_in,
  input wire logic panel_lr_key_in,
  input wire logic stop_cmd_in,
  input wire logic [15:0] out_freq_in,
  input wire logic [15:0] stored_hold_freq_in,
  input wire logic [15:0] voltage_recovery_time_in,
  output logic [7:0] sel_rd_data_out,
  output logic sel_reject_out,
  output logic local_mode_out,
  output logic lr_key_enable_out,
  output logic run_cmd_out,
  output logic stop_disable_out,
  output logic option_ref_out,
  output logic baseblock_out,
  output logic [15:0] retained_freq_out,
  output logic speed_search_out,
  output logic volt_recover_out,
  output logic ramp_hold_out,
  output logic hold_zero_out,
  output logic [15:0] hold_freq_out,
  output logic hold_store_wr_out,
  output logic setting_conflict_error_out,
  output logic overheat_warning_out,
  output logic analog_enable_out,
  output logic encoder_feedback_disable_out,
  output logic speed_loop_p_only_out
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic fn_asg(input logic [5:0][7:0] s, input logic [7:0] c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < mfi_pkg::NUM_TERM; i++) begin
      r = r | (s[i] == c);
    end
    return r;
  endfunction : fn_asg

  function automatic logic fn_on(input logic [5:0][7:0] s, input logic [5:0] t,
                                 input logic [7:0] c);
    logic r;
    r = 1'b0;
    for (int i = 0; i < mfi_pkg::NUM_TERM; i++) begin
      r = r | ((s[i] == c) & t[i]);
    end
    return r;
  endfunction : fn_on

  // ****************************************
  // Reset release and terminal sync
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [5:0] t1_q, t2_q, t3_q, term_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      t1_q <= 6'h00;
      t2_q <= 6'h00;
      t3_q <= 6'h00;
      term_q <= 6'h00;
    end else begin
      t1_q <= terminal_in; // [R23]
      t2_q <= t1_q;
      t3_q <= t2_q;
      term_q <= (term_q & (t2_q ^ t3_q)) | (t2_q & ~(t2_q ^ t3_q)); // [R23]
    end
  end

  // ****************************************
  // Selector registers
  // ****************************************
  logic [5:0][7:0] sel_q;
  wire wr_ok = sel_wr_in.wr_en && !running_in && sel_wr_in.data <= mfi_pkg::CODE_MAX &&
               sel_wr_in.idx < 3'(mfi_pkg::NUM_TERM);
  wire wr_bad = sel_wr_in.wr_en && !wr_ok;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= mfi_pkg::SEL_RESET; // [R02]
      sel_reject_out <= 1'b0;
      sel_rd_data_out <= 8'h00;
    end else begin
      if (load_three_wire_in && !running_in) begin
        sel_q <= mfi_pkg::SEL_3WIRE; // [R02]
      end else if (load_defaults_in && !running_in) begin
        sel_q <= mfi_pkg::SEL_RESET; // [R02]
      end else if (wr_ok) begin
        sel_q[sel_wr_in.idx] <= sel_wr_in.data; // [R01]
      end
      sel_reject_out <= wr_bad; // [R01]
      sel_rd_data_out <= (sel_rd_idx_in < 3'(mfi_pkg::NUM_TERM)) ? sel_q[sel_rd_idx_in] : 8'h00;
    end
  end

  // ****************************************
  // Function decode
  // ****************************************
  wire lr_asg = fn_asg(sel_q, mfi_pkg::FN_LOCAL_REMOTE);
  wire lr_on = fn_on(sel_q, term_q, mfi_pkg::FN_LOCAL_REMOTE);
  wire opt_on = fn_on(sel_q, term_q, mfi_pkg::FN_OPTION_REF);
  wire bb_cmd = fn_on(sel_q, term_q, mfi_pkg::FN_BB_NO) |
                fn_on(sel_q, ~term_q, mfi_pkg::FN_BB_NC); // [R10]
  wire hold_on = fn_on(sel_q, term_q, mfi_pkg::FN_RAMP_HOLD);
  wire oh_on = fn_on(sel_q, term_q, mfi_pkg::FN_OVERHEAT);
  wire an_asg = fn_asg(sel_q, mfi_pkg::FN_ANALOG_EN);
  wire an_on = fn_on(sel_q, term_q, mfi_pkg::FN_ANALOG_EN);
  wire fb_on = fn_on(sel_q, term_q, mfi_pkg::FN_FB_SELECT);
  wire ir_on = fn_on(sel_q, term_q, mfi_pkg::FN_INT_RESET);
  wire g_hold = fn_asg(sel_q, mfi_pkg::FN_RAMP_HOLD);
  wire g_updn = fn_asg(sel_q, mfi_pkg::FN_UP) | fn_asg(sel_q, mfi_pkg::FN_DOWN);
  wire g_trim = fn_asg(sel_q, mfi_pkg::FN_TRIM_UP) | fn_asg(sel_q, mfi_pkg::FN_TRIM_DN);
  wire g_samp = fn_asg(sel_q, mfi_pkg::FN_SAMPLE_HOLD);
  wire [2:0] grp_cnt = 3'(g_hold) + 3'(g_updn) + 3'(g_trim) + 3'(g_samp);
  wire conflict = grp_cnt > 3'h1; // [R17]
  wire ir_ok = ir_on && cfg_in.encoder_vf_mode && !cfg_in.ramp_integral_setting; // [R22]

  // ****************************************
  // Local/remote and reference source
  // ****************************************
  logic local_q, run_block_q, opt_q, key_q;
  wire key_press = panel_lr_key_in && !key_q;
  wire local_d = lr_asg ? lr_on : (key_press ? !local_q : local_q); // [R05]
  wire to_remote = local_q && !local_d && !running_in;
  wire run_remote = remote_run_in && !run_block_q;
  wire run_sel = local_q ? panel_run_in : run_remote; // [R03]

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      local_q <= 1'b0;
      run_block_q <= 1'b0;
      opt_q <= 1'b0;
      key_q <= 1'b0;
    end else begin
      key_q <= panel_lr_key_in;
      if (!running_in) begin
        local_q <= local_d; // [R04]
        opt_q <= opt_on; // [R08]
      end
      if (to_remote && remote_run_in && !cfg_in.run_on_switch_accept) begin
        run_block_q <= 1'b1; // [R06]
      end else if (!remote_run_in) begin
        run_block_q <= 1'b0; // [R06]
      end
    end
  end

  // ****************************************
  // Baseblock, retained frequency, recovery
  // ****************************************
  logic bb_q, ss_q;
  logic [16:0] unit_cnt_q;
  logic [15:0] recov_q, retain_q;
  wire unit_tick = unit_cnt_q == 17'(RECOVERY_UNIT_CYC - 1);
  wire bb_clear = bb_q && !bb_cmd;
  wire [15:0] recov_d = bb_cmd ? 16'h0000 : bb_clear ? voltage_recovery_time_in :
                        (unit_tick && recov_q != 16'h0000) ? recov_q - 16'h0001 : recov_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bb_q <= 1'b0;
      ss_q <= 1'b0;
      unit_cnt_q <= 17'h00000;
      recov_q <= 16'h0000;
      retain_q <= 16'h0000;
      volt_recover_out <= 1'b0;
    end else begin
      bb_q <= bb_cmd; // [R10]
      if (!run_sel) begin
        retain_q <= 16'h0000; // [R11]
      end else if (bb_cmd && !bb_q) begin
        retain_q <= out_freq_in; // [R11]
      end
      ss_q <= bb_clear && run_sel; // [R11]
      unit_cnt_q <= (unit_tick || bb_clear) ? 17'h00000 : unit_cnt_q + 17'h00001;
      recov_q <= recov_d; // [R12]
      volt_recover_out <= recov_d != 16'h0000; // [R12]
    end
  end

  // ****************************************
  // Ramp hold
  // ****************************************
  logic run_q, hold_q, zero_q;
  logic [15:0] hold_freq_q;
  wire run_start = run_sel && !run_q;
  wire hold_act = hold_on && run_sel && !stop_cmd_in; // [R14]

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      hold_q <= 1'b0;
      zero_q <= 1'b0;
      hold_freq_q <= 16'h0000;
      hold_store_wr_out <= 1'b0;
    end else begin
      run_q <= run_sel;
      hold_q <= hold_act; // [R13]
      hold_store_wr_out <= hold_act && !hold_q && cfg_in.reference_hold_store; // [R15]
      if (run_start && hold_on) begin
        hold_freq_q <= cfg_in.reference_hold_store ? stored_hold_freq_in : 16'h0000; // [R15]
      end else if (hold_act && !hold_q) begin
        hold_freq_q <= out_freq_in; // [R13]
      end
      if (run_start && hold_on && !cfg_in.reference_hold_store) begin
        zero_q <= 1'b1; // [R16]
      end else if (!hold_act) begin
        zero_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      local_mode_out <= 1'b0;
      lr_key_enable_out <= 1'b0;
      run_cmd_out <= 1'b0;
      stop_disable_out <= 1'b0;
      option_ref_out <= 1'b0;
      setting_conflict_error_out <= 1'b0;
      overheat_warning_out <= 1'b0;
      analog_enable_out <= 1'b0;
      encoder_feedback_disable_out <= 1'b0;
      speed_loop_p_only_out <= 1'b0;
    end else begin
      local_mode_out <= local_q; // [R03]
      lr_key_enable_out <= !lr_asg; // [R04] [R05]
      run_cmd_out <= run_sel; // [R03]
      stop_disable_out <= local_q && !cfg_in.three_wire_setting; // [R07]
      option_ref_out <= (cfg_in.reference_source_select == mfi_pkg::REF_SRC_OPTION) ||
                        opt_q; // [R09]
      setting_conflict_error_out <= conflict; // [R17]
      overheat_warning_out <= oh_on; // [R18]
      analog_enable_out <= !an_asg || an_on; // [R19]
      encoder_feedback_disable_out <= fb_on; // [R20]
      speed_loop_p_only_out <= ir_ok; // [R21]
    end
  end

  assign baseblock_out = bb_q;
  assign retained_freq_out = retain_q;
  assign speed_search_out = ss_q;
  assign ramp_hold_out = hold_q;
  assign hold_zero_out = zero_q;
  assign hold_freq_out = hold_freq_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  a_sel_no_write_run: assert property (running_in && !load_defaults_in && !load_three_wire_in
    |=> $stable(sel_q)) else $error("Selector changed while running"); // [R01]
  a_sel_reject_flag: assert property (sel_wr_in.wr_en && sel_wr_in.data > mfi_pkg::CODE_MAX
    |=> sel_reject_out) else $error("Out of range code not refused"); // [R01]
  a_local_only_stopped: assert property (running_in |=> $stable(local_q))
    else $error("Source switched while running"); // [R04]
  a_key_disabled: assert property (lr_asg |=> !lr_key_enable_out)
    else $error("Panel key enabled with code 01 assigned"); // [R05]
  a_run_block_hold: assert property (run_block_q && remote_run_in && !local_q
    |=> !run_cmd_out) else $error("Blocked run passed"); // [R06]
  a_bb_nc_level: assert property (fn_asg(sel_q, mfi_pkg::FN_BB_NC) && term_q == 6'h00
    |=> baseblock_out)
    else $error("Normally closed baseblock missed"); // [R10]
  a_retain_clear: assert property (!run_sel |=> retained_freq_out == 16'h0000)
    else $error("Retained frequency not cleared"); // [R11]
  a_recover_start: assert property (bb_clear && voltage_recovery_time_in != 16'h0000
    |=> volt_recover_out [*2]) else $error("Voltage recovery not started"); // [R12]
  a_stop_no_hold: assert property (stop_cmd_in |=> !ramp_hold_out)
    else $error("Ramp hold kept over stop"); // [R14]
  a_conflict_err: assert property (g_samp && (g_hold || g_updn || g_trim)
    |=> setting_conflict_error_out)
    else $error("Conflict not flagged"); // [R17]
  a_int_reset_mode: assert property (!cfg_in.encoder_vf_mode |=> !speed_loop_p_only_out)
    else $error("Integral reset outside encoder mode"); // [R22]

  c_remote_block: cover property (to_remote ##1 run_block_q);
  c_bb_recover: cover property (bb_clear ##1 volt_recover_out);
  c_hold_zero: cover property (run_start && hold_on ##1 hold_zero_out);
  c_conflict: cover property (conflict);

endmodule : mfi_decoder

`default_nettype wire

// ---- design/mfi_pkg.sv ----
// Purpose: Constants and carrier types for the multi-function input decoder
// Assumes: One 125 MHz clock, selector codes written through the selector port
// Notes: Function codes are hexadecimal, as the selector values are
//
// Overview of operation
// [R01] Six terminal selectors, codes 00 to 77, writes refused while running.
// [R02] Defaults 24,14,03,04,06,08; three-wire init loads 00,03,04,06 in selectors 3-6.
// [R03] Code 01 on: panel reference and run; off: configured sources.
// [R04] Local/remote source changes only while stopped; panel key disabled when assigned.
// [R05] Panel local/remote key disabled whenever any terminal carries code 01.
// [R06] Run held at local-to-remote switch until cycled, unless run-on-switch accept set.
// [R07] Inputs active in both modes; local stop disabled only when three-wire setting 0.
// [R08] Code 02 on selects option card reference; switches only while stopped.
// [R09] Reference source 3 forces option card reference regardless of code 02.
// [R10] Baseblock output interrupt: code 08 active on, code 09 active off.
// [R11] Baseblock retains frequency, speed search on clear; run off clears it.
// [R12] After baseblock clears, voltage recovers over the recovery time.
// [R13] Code 0A on freezes ramp and holds frequency; off resumes ramping.
// [R14] Stop command still stops the motor while ramp hold is on.
// [R15] Hold store 1 saves held frequency; run with hold on restarts there.
// [R16] Hold store 0 with run given under hold on keeps frequency zero.
// [R17] Conflict error when more than one of 0A, 10/11, 1C/1D, 1E assigned.
// [R18] Code 0B shows overheat warning while on, self-clearing, no fault.
// [R19] Code 0C enables analog input only while on; off acts as function 1F.
// [R20] Code 0D on disables encoder speed feedback, switchable while running.
// [R21] Code 0E on: proportional-only speed loop with integral reset.
// [R22] Integral reset honoured only in encoder V/f mode with ramp integral 0.
// [R23] Each terminal synchronised before decoding.
package mfi_pkg;

  localparam int NUM_TERM = 6;
  localparam logic [7:0] CODE_MAX = 8'h77;

  // Function codes
  localparam logic [7:0] FN_LOCAL_REMOTE = 8'h01;
  localparam logic [7:0] FN_OPTION_REF = 8'h02;
  localparam logic [7:0] FN_BB_NO = 8'h08;
  localparam logic [7:0] FN_BB_NC = 8'h09;
  localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
  localparam logic [7:0] FN_OVERHEAT = 8'h0B;
  localparam logic [7:0] FN_ANALOG_EN = 8'h0C;
  localparam logic [7:0] FN_FB_SELECT = 8'h0D;
  localparam logic [7:0] FN_INT_RESET = 8'h0E;
  localparam logic [7:0] FN_UP = 8'h10;
  localparam logic [7:0] FN_DOWN = 8'h11;
  localparam logic [7:0] FN_TRIM_UP = 8'h1C;
  localparam logic [7:0] FN_TRIM_DN = 8'h1D;
  localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;

  localparam logic [1:0] REF_SRC_OPTION = 2'h3;

  // Reset and three-wire defaults, selector 5 first
  localparam logic [5:0][7:0] SEL_RESET = {8'h08, 8'h06, 8'h04, 8'h03, 8'h14, 8'h24};
  localparam logic [5:0][7:0] SEL_3WIRE = {8'h06, 8'h04, 8'h03, 8'h00, 8'h14, 8'h24};

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RECOVERY_UNIT_NS = 1000000;
  localparam int RECOVERY_UNIT_CYCLES = RECOVERY_UNIT_NS / CLK_PERIOD_NS;

  // Drive configuration settings
  typedef struct packed {
    logic [1:0] reference_source_select;
    logic run_source_select;
    logic run_on_switch_accept;
    logic reference_hold_store;
    logic ramp_integral_setting;
    logic three_wire_setting;
    logic encoder_vf_mode;
  } mfi_cfg_t;

  // Selector write request
  typedef struct packed {
    logic wr_en;
    logic [2:0] idx;
    logic [7:0] data;
  } mfi_sel_wr_t;

endpackage : mfi_pkg

// ---- sim/mfi_contacts.sv ----
// Purpose: Model of the contacts that drive the six input terminals
// Assumes: Contacts change just after the falling clock edge
// Notes: With slow_in set, a change reaches the pins a few cycles late
`timescale 1ns/1ps
`default_nettype none

module mfi_contacts (
  input wire logic clk_in,
  input wire logic [5:0] want_in,
  input wire logic slow_in,
  output logic [5:0] terminal_out
);
  logic [1:0] lag_q;

  initial terminal_out = 6'h00;
  initial lag_q = 2'h0;

  // Pins follow the wanted level, late when slow
  always @(negedge clk_in) begin
    if (want_in == terminal_out) lag_q <= 2'h0;
    else if (!slow_in || lag_q == 2'h3) terminal_out <= want_in;
    else lag_q <= lag_q + 2'h1;
  end
endmodule : mfi_contacts

`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the multi-function input decoder
// Assumes: Recovery unit shortened to 4 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {logic [7:0] code; logic on; logic [9:0] exp;} mfi_row_t;
  logic clk = 1'b0, arst_n = 1'b0, running = 1'b0, panel_run = 1'b0, remote_run = 1'b0;
  logic lr_key = 1'b0, stop_cmd = 1'b0, ld_def = 1'b0, ld_3w = 1'b0, slow = 1'b0;
  logic [5:0] want = 6'h00;
  logic [5:0] term;
  logic [2:0] rd_idx = 3'h0;
  logic [15:0] out_freq = 16'h04D2, stored_freq = 16'h0BB8, vr_time = 16'h0003;
  mfi_pkg::mfi_cfg_t cfg = '0;
  mfi_pkg::mfi_sel_wr_t wr = '0;
  logic [7:0] rd_data;
  logic [15:0] ret_freq, hold_freq;
  logic reject, local_m, lr_en, run_cmd, stop_dis, opt, bb, ss, vr, rhold, hzero, hswr;
  logic conflict, oh, ana, encd, ponly;
  logic [9:0] lv;
  int fails = 0, samples_checked = 0, rej_cnt = 0, ss_cnt = 0, hsw_cnt = 0, i;
  logic [7:0] dflt [6] = '{8'h24, 8'h14, 8'h03, 8'h04, 8'h06, 8'h08};
  logic [7:0] t3w [6] = '{8'h24, 8'h14, 8'h00, 8'h03, 8'h04, 8'h06};
  // Bits: local, stop off, key on, option, baseblock, hold, overheat, analog, fb off, p only
  mfi_row_t rows [13] = '{'{8'h00, 1'b1, 10'h084}, '{8'h01, 1'b1, 10'h304},
    '{8'h01, 1'b0, 10'h004}, '{8'h02, 1'b1, 10'h0C4}, '{8'h08, 1'b1, 10'h0A4},
    '{8'h09, 1'b0, 10'h0A4}, '{8'h09, 1'b1, 10'h084}, '{8'h0A, 1'b1, 10'h084},
    '{8'h0B, 1'b1, 10'h08C}, '{8'h0C, 1'b0, 10'h080}, '{8'h0C, 1'b1, 10'h084},
    '{8'h0D, 1'b1, 10'h086}, '{8'h0E, 1'b1, 10'h085}};

  assign lv = {local_m, stop_dis, lr_en, opt, bb, rhold, oh, ana, encd, ponly};

  mfi_contacts u_mfi_contacts (.clk_in(clk), .want_in(want), .slow_in(slow), .terminal_out(term));

  mfi_decoder #(.RECOVERY_UNIT_CYC(4)) u_mfi_decoder (
    .sys_clk_in(clk), .arst_n_in(arst_n), .terminal_in(term), .sel_wr_in(wr),
    .sel_rd_idx_in(rd_idx), .load_defaults_in(ld_def), .load_three_wire_in(ld_3w),
    .cfg_in(cfg), .running_in(running), .panel_run_in(panel_run),
    .remote_run_in(remote_run), .panel_lr_key_in(lr_key), .stop_cmd_in(stop_cmd),
    .out_freq_in(out_freq), .stored_hold_freq_in(stored_freq),
    .voltage_recovery_time_in(vr_time), .sel_rd_data_out(rd_data), .sel_reject_out(reject),
    .local_mode_out(local_m), .lr_key_enable_out(lr_en), .run_cmd_out(run_cmd),
    .stop_disable_out(stop_dis), .option_ref_out(opt), .baseblock_out(bb),
    .retained_freq_out(ret_freq), .speed_search_out(ss), .volt_recover_out(vr),
    .ramp_hold_out(rhold), .hold_zero_out(hzero), .hold_freq_out(hold_freq),
    .hold_store_wr_out(hswr), .setting_conflict_error_out(conflict),
    .overheat_warning_out(oh), .analog_enable_out(ana),
    .encoder_feedback_disable_out(encd), .speed_loop_p_only_out(ponly));

  // ************
  // Helpers
  // ************
  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reject === 1'b1) rej_cnt <= rej_cnt + 1;
    if (ss === 1'b1) ss_cnt <= ss_cnt + 1;
    if (hswr === 1'b1) hsw_cnt <= hsw_cnt + 1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wsel(input logic [2:0] idx, input logic [7:0] data);
    wr = {1'b1, idx, data};
    cyc(1);
    wr.wr_en = 1'b0;
    cyc(1);
  endtask : wsel

  task automatic rdsel(input logic [2:0] idx, input logic [7:0] exp);
    rd_idx = idx;
    cyc(2);
    check("sel_rd_data", rd_data, exp);
  endtask : rdsel

  task automatic tally_and_finish;
    $display("Checked %0d values, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    fails++;
    $display("Watchdog expired");
    tally_and_finish();
  end

  // ************
  // Tests
  // ************
  initial begin
    cfg.encoder_vf_mode = 1'b1;
    cyc(16);
    check("reset_levels", lv, 10'h000);
    arst_n = 1'b1;
    cyc(4);
    for (i = 0; i < 6; i++) rdsel(i[2:0], dflt[i]);
    $display("Test reset done");
    wsel(3'h0, 8'h00);
    for (i = 0; i < 13; i++) begin
      wsel(3'h0, rows[i].code);
      want[0] = rows[i].on;
      slow = i[0];
      cyc(14);
      check("levels", lv, rows[i].exp);
    end
    slow = 1'b0;
    $display("Test table done");
    wsel(3'h1, 8'h77);
    running = 1'b1;
    wsel(3'h1, 8'h05);
    running = 1'b0;
    wsel(3'h1, 8'h78);
    wsel(3'h6, 8'h05);
    cyc(2);
    check("reject_count", rej_cnt, 3);
    rdsel(3'h1, 8'h77);
    rdsel(3'h6, 8'h00);
    ld_3w = 1'b1;
    cyc(1);
    ld_3w = 1'b0;
    for (i = 0; i < 6; i++) rdsel(i[2:0], t3w[i]);
    ld_def = 1'b1;
    cyc(1);
    ld_def = 1'b0;
    for (i = 0; i < 6; i++) rdsel(i[2:0], dflt[i]);
    $display("Test selectors done");
    want = 6'h00;
    wsel(3'h0, 8'h0A);
    wsel(3'h1, 8'h1C);
    cyc(3);
    check("conflict_trim", conflict, 1'b1);
    wsel(3'h1, 8'h14);
    cyc(3);
    check("conflict_none", conflict, 1'b0);
    wsel(3'h0, 8'h10);
    wsel(3'h1, 8'h1E);
    cyc(3);
    check("conflict_hold", conflict, 1'b1);
    wsel(3'h1, 8'h11);
    cyc(3);
    check("conflict_pair", conflict, 1'b0);
    $display("Test conflict done");
    wsel(3'h0, 8'h01);
    running = 1'b1;
    want[0] = 1'b1;
    cyc(14);
    check("local_running", local_m, 1'b0);
    running = 1'b0;
    cyc(4);
    check("local_stopped", local_m, 1'b1);
    cfg.three_wire_setting = 1'b1;
    cyc(2);
    check("stop_kept_3wire", stop_dis, 1'b0);
    cfg.three_wire_setting = 1'b0;
    cyc(2);
    check("stop_disabled", stop_dis, 1'b1);
    remote_run = 1'b1;
    want[0] = 1'b0;
    cyc(14);
    check("run_blocked", run_cmd, 1'b0);
    remote_run = 1'b0;
    cyc(3);
    remote_run = 1'b1;
    cyc(3);
    check("run_recycled", run_cmd, 1'b1);
    cfg.run_on_switch_accept = 1'b1;
    want[0] = 1'b1;
    cyc(14);
    want[0] = 1'b0;
    cyc(14);
    check("run_accepted", run_cmd, 1'b1);
    cfg.run_on_switch_accept = 1'b0;
    $display("Test local remote done");
    wsel(3'h0, 8'h02);
    cfg.reference_source_select = 2'h3;
    cyc(4);
    check("option_forced", opt, 1'b1);
    cfg.reference_source_select = 2'h0;
    wsel(3'h0, 8'h08);
    want[0] = 1'b1;
    cyc(14);
    check("bb_on", bb, 1'b1);
    check("bb_retained", ret_freq, 16'h04D2);
    want[0] = 1'b0;
    cyc(8);
    check("speed_search", ss_cnt, 1);
    check("recover_on", vr, 1'b1);
    cyc(20);
    check("recover_off", vr, 1'b0);
    want[0] = 1'b1;
    cyc(14);
    remote_run = 1'b0;
    cyc(4);
    check("retained_cleared", ret_freq, 16'h0000);
    want[0] = 1'b0;
    $display("Test baseblock done");
    wsel(3'h0, 8'h0A);
    want[0] = 1'b1;
    cyc(14);
    remote_run = 1'b1;
    cyc(4);
    check("hold_zero", hzero, 1'b1);
    check("hold_engaged", rhold, 1'b1);
    stop_cmd = 1'b1;
    cyc(4);
    check("hold_stopped", hzero, 1'b0);
    stop_cmd = 1'b0;
    remote_run = 1'b0;
    cfg.reference_hold_store = 1'b1;
    cyc(4);
    remote_run = 1'b1;
    cyc(4);
    check("hold_restart", hold_freq, 16'h0BB8);
    check("hold_store_wr", hsw_cnt, 1);
    $display("Test ramp hold done");
    wsel(3'h0, 8'h0E);
    cfg.encoder_vf_mode = 1'b0;
    cyc(4);
    check("p_only_mode", ponly, 1'b0);
    cfg.encoder_vf_mode = 1'b1;
    cfg.ramp_integral_setting = 1'b1;
    cyc(4);
    check("p_only_integral", ponly, 1'b0);
    $display("Test integral reset done");
    lr_key = 1'b1;
    cyc(3);
    check("key_local", local_m, 1'b1);
    check("key_enabled", lr_en, 1'b1);
    lr_key = 1'b0;
    $display("Test panel key done");
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
